// ---- hw/frbw_cfg.svh ----
// Constants of the fault resilient boot watchdog
`ifndef FRBW_CFG_SVH
`define FRBW_CFG_SVH

// ==========================================================
// Clock and timing
`define FRBW_CLK_PERIOD_NS     10
`define FRBW_NS_PER_MS         1000000
`define FRBW_RECOV_PULSE_MS    10
`define FRBW_BOOT_TIMEOUT_MS   500
`define FRBW_POST_TIMEOUT_MS   2000

// ==========================================================
// Widths and constant values
`define FRBW_CNT_W             32
`define FRBW_CPU_N             2
`define FRBW_CNT_ZERO          32'h0000_0000
`define FRBW_CNT_ONE           32'h0000_0001

`endif

// ---- hw/frbw_pkg.sv ----
// Types of the fault resilient boot watchdog
package frbw_pkg;

    // ======================================================
    // Recovery sequence states, Gray along the path
    typedef enum logic [1:0] {
        ST_BOOT_WAIT = 2'h0,
        ST_RECOVER   = 2'h1,
        ST_SWITCHED  = 2'h3,
        ST_HALTED    = 2'h2
    } frbw_fsm_t;

    // ======================================================
    // Error inputs of both processors
    typedef struct packed {
        logic [1:0] thermal_trip;
        logic [1:0] internal_error;
    } frbw_err_t;

    // ======================================================
    // Status word answered on a poll
    typedef struct packed {
        frbw_err_t  err_now;
        frbw_err_t  err_seen;
        frbw_fsm_t  fsm;
        logic       boot_timeout;
        logic       post_timeout;
        logic       recovery_enabled;
        logic       two_cpus;
    } frbw_status_t;

    // ======================================================
    // Whole state of the watchdog
    typedef struct packed {
        frbw_fsm_t    fsm;
        logic [31:0]  boot_cnt;
        logic [31:0]  post_cnt;
        logic [31:0]  pulse_cnt;
        logic         strap_taken;
        logic         recovery_enabled;
        logic         two_cpus;
        logic         boot_timeout;
        logic         post_timeout;
        logic         stop_flush;
        logic         recovery_reset_n;
        logic         primary_bsp_inhibit;
        frbw_err_t    err_prev;
        frbw_err_t    err_seen;
        frbw_status_t status;
        logic         status_valid;
        logic         alert;
    } frbw_regs_t;

endpackage

// ---- hw/frbw_watchdog.sv ----
// Boot watchdog, processor failover and error monitor

`timescale 1ns/1ns
`default_nettype none
`include "frbw_cfg.svh"

module frbw_watchdog #(
    parameter int unsigned BOOT_TIMEOUT_CYCLES =
        `FRBW_BOOT_TIMEOUT_MS * (`FRBW_NS_PER_MS / `FRBW_CLK_PERIOD_NS),
    parameter int unsigned POST_TIMEOUT_CYCLES =
        `FRBW_POST_TIMEOUT_MS * (`FRBW_NS_PER_MS / `FRBW_CLK_PERIOD_NS),
    parameter int unsigned RECOV_PULSE_CYCLES =
        `FRBW_RECOV_PULSE_MS * (`FRBW_NS_PER_MS / `FRBW_CLK_PERIOD_NS)
) (
    // Clock and power-up reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // Boot watchdog control from the processor
    input  wire logic                  boot_timer_halt_n,
    input  wire logic                  post_wdt_arm,
    input  wire logic                  post_wdt_kick,
    // Board straps
    input  wire logic                  recovery_enable_strap,
    input  wire logic                  two_cpus_installed,
    // Processor error inputs
    input  wire frbw_pkg::frbw_err_t   cpu_err,
    // Status poll and alert configuration
    input  wire logic                  status_poll,
    input  wire logic                  alert_enable,
    // Recovery outputs
    output logic                       stop_flush,
    output logic                       boot_recovery_reset_n,
    output logic                       primary_bsp_inhibit,
    // Status and alert outputs
    output frbw_pkg::frbw_status_t     status,
    output logic                       status_valid,
    output logic                       alert
);

    // ======================================================
    // Counter limits
    localparam logic [`FRBW_CNT_W-1:0] BOOT_LAST =
        `FRBW_CNT_W'(BOOT_TIMEOUT_CYCLES - 1);
    localparam logic [`FRBW_CNT_W-1:0] POST_LAST =
        `FRBW_CNT_W'(POST_TIMEOUT_CYCLES - 1);
    localparam logic [`FRBW_CNT_W-1:0] PULSE_LAST =
        `FRBW_CNT_W'(RECOV_PULSE_CYCLES - 1);

    // ======================================================
    // State
    frbw_pkg::frbw_regs_t state_reg;
    frbw_pkg::frbw_regs_t state_next;

    // Counter end points and next counts
    logic                   boot_expired;
    logic                   post_expired;
    logic                   pulse_done;
    logic [`FRBW_CNT_W-1:0] boot_cnt_inc;
    logic [`FRBW_CNT_W-1:0] post_cnt_inc;
    logic [`FRBW_CNT_W-1:0] pulse_cnt_inc;

    // Processor controls and recovery decisions
    logic                   strap_capture;
    logic                   halt_seen;
    logic                   post_restart;
    logic                   boot_timeout_hit;
    logic                   post_timeout_hit;
    logic                   may_switch;
    logic                   boot_pulse_start;
    logic                   post_pulse_start;

    // Error monitor and status answer
    logic [3:0]             err_rise;
    logic                   err_new;
    logic                   alert_fire;
    frbw_pkg::frbw_err_t    err_seen_now;
    frbw_pkg::frbw_status_t status_answer;

    // ======================================================
    // Next state
    always_comb begin
        // ==================================================
        // Hold all state by default
        state_next   = state_reg;

        // ==================================================
        // One-cycle pulses default low
        state_next.status_valid = 1'b0;
        state_next.alert        = 1'b0;

        // ==================================================
        // Strap levels caught on the first edge after reset
        strap_capture = ~state_reg.strap_taken;
        if (strap_capture) begin
            state_next.strap_taken      = 1'b1;
            state_next.recovery_enabled = recovery_enable_strap;
            state_next.two_cpus         = two_cpus_installed;
        end

        // ==================================================
        // Counter end points
        boot_expired = (state_reg.boot_cnt == BOOT_LAST);
        post_expired = (state_reg.post_cnt == POST_LAST);
        pulse_done   = (state_reg.pulse_cnt == PULSE_LAST);

        // ==================================================
        // Next counts
        boot_cnt_inc  = state_reg.boot_cnt + `FRBW_CNT_ONE;
        post_cnt_inc  = state_reg.post_cnt + `FRBW_CNT_ONE;
        pulse_cnt_inc = state_reg.pulse_cnt + `FRBW_CNT_ONE;

        // ==================================================
        // Processor and self-test controls
        halt_seen        = ~boot_timer_halt_n;
        post_restart     = ~post_wdt_arm | post_wdt_kick;
        boot_timeout_hit = ~halt_seen & state_reg.strap_taken
                         & boot_expired;
        post_timeout_hit = ~post_restart & post_expired;

        // ==================================================
        // Failover only when allowed and a second processor exists
        may_switch   = state_reg.recovery_enabled
                     & state_reg.two_cpus;

        // ==================================================
        // Level 3: boot counter ran out before any halt
        boot_pulse_start = (state_reg.fsm == frbw_pkg::ST_BOOT_WAIT)
                         & boot_timeout_hit
                         & may_switch;

        // ==================================================
        // Level 2: self-test count ran out, primary not yet barred
        post_pulse_start = (state_reg.fsm == frbw_pkg::ST_HALTED)
                         & post_timeout_hit
                         & may_switch
                         & ~state_reg.primary_bsp_inhibit;

        // ==================================================
        // Error monitor inputs
        err_rise     = cpu_err & ~state_reg.err_prev;
        err_new      = (err_rise != 4'h0);
        err_seen_now = state_reg.err_seen | cpu_err;

        // ==================================================
        // Alert request on a new error when configured
        alert_fire   = alert_enable & err_new;

        // ==================================================
        // Status answer, taken over only on a poll
        status_answer                  = '0;
        status_answer.err_now          = cpu_err;
        status_answer.err_seen         = err_seen_now;
        status_answer.fsm              = state_reg.fsm;
        status_answer.boot_timeout     = state_reg.boot_timeout;
        status_answer.post_timeout     = state_reg.post_timeout;
        status_answer.recovery_enabled = state_reg.recovery_enabled;
        status_answer.two_cpus         = state_reg.two_cpus;

        // ==================================================
        // Level 1 self-test failures are left to firmware entirely

        // ==================================================
        // Recovery sequence
        unique case (state_reg.fsm)

            // ==============================================
            // Waiting for the processor to halt the counter
            frbw_pkg::ST_BOOT_WAIT: begin
                // Counting from power-up, no software needed
                if (halt_seen) begin
                    state_next.fsm = frbw_pkg::ST_HALTED;
                end else if (boot_timeout_hit) begin
                    state_next.boot_timeout = 1'b1;
                    if (boot_pulse_start) begin
                        state_next.fsm              = frbw_pkg::ST_RECOVER;
                        state_next.stop_flush       = 1'b1;
                        state_next.recovery_reset_n = 1'b0;
                        state_next.pulse_cnt        = `FRBW_CNT_ZERO;
                    end else begin
                        state_next.fsm = frbw_pkg::ST_HALTED;
                    end
                end else begin
                    state_next.boot_cnt = boot_cnt_inc;
                end
            end

            // ==============================================
            // Boot counter stopped, self-test watchdog active
            frbw_pkg::ST_HALTED: begin
                // Level 2 watchdog runs while self-test is armed
                if (post_restart) begin
                    state_next.post_cnt = `FRBW_CNT_ZERO;
                end else if (post_timeout_hit) begin
                    state_next.post_timeout = 1'b1;
                    state_next.post_cnt     = `FRBW_CNT_ZERO;
                    if (post_pulse_start) begin
                        state_next.fsm              = frbw_pkg::ST_RECOVER;
                        state_next.stop_flush       = 1'b1;
                        state_next.recovery_reset_n = 1'b0;
                        state_next.pulse_cnt        = `FRBW_CNT_ZERO;
                    end
                end else begin
                    state_next.post_cnt = post_cnt_inc;
                end
            end

            // ==============================================
            // Recovery reset pulse
            frbw_pkg::ST_RECOVER: begin
                // Reset pulse of fixed length
                if (pulse_done) begin
                    state_next.fsm                 = frbw_pkg::ST_SWITCHED;
                    state_next.recovery_reset_n    = 1'b1;
                    state_next.stop_flush          = 1'b0;
                    state_next.primary_bsp_inhibit = 1'b1;
                end else begin
                    state_next.pulse_cnt = pulse_cnt_inc;
                end
            end

            // ==============================================
            // Alternate processor booting
            frbw_pkg::ST_SWITCHED: begin
                // Alternate processor boots; primary stays barred
                state_next.primary_bsp_inhibit = 1'b1;
                state_next.post_cnt            = `FRBW_CNT_ZERO;
                if (halt_seen) begin
                    state_next.fsm = frbw_pkg::ST_HALTED;
                end
            end

        endcase

        // ==================================================
        // Previous error levels, for edge detection
        state_next.err_prev = cpu_err;

        // ==================================================
        // Error history, a new error wins over the poll clear
        if (status_poll) begin
            state_next.err_seen = cpu_err;
        end else begin
            state_next.err_seen = err_seen_now;
        end

        // ==================================================
        // Alert on a new error when configured
        if (alert_fire) begin
            state_next.alert = 1'b1;
        end

        // ==================================================
        // Status answer one cycle after the poll
        if (status_poll) begin
            state_next.status_valid = 1'b1;
            state_next.status       = status_answer;
        end
    end

    // ======================================================
    // Registers, all reloaded at power-up
    always_ff @(posedge core_clk) begin
        if (rst) begin
            // Pins idle, counters and error history cleared
            state_reg                  <= '0;
            state_reg.fsm              <= frbw_pkg::ST_BOOT_WAIT;
            state_reg.recovery_reset_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ======================================================
    // Recovery pins
    assign stop_flush            = state_reg.stop_flush;
    assign boot_recovery_reset_n = state_reg.recovery_reset_n;
    assign primary_bsp_inhibit   = state_reg.primary_bsp_inhibit;

    // ======================================================
    // Status pins
    assign status                = state_reg.status;
    assign status_valid          = state_reg.status_valid;
    assign alert                 = state_reg.alert;

endmodule // frbw_watchdog

`default_nettype wire

// ---- testbench/frbw_props.sv ----
// Checker of the boot watchdog pins
`timescale 1ns/1ns
`default_nettype none
module frbw_props #(parameter int unsigned RECOV_PULSE_CYCLES = 10) (
    // Inputs
    input wire logic                core_clk,
    input wire logic                rst,
    input wire logic                boot_timer_halt_n,
    input wire logic                post_wdt_arm,
    input wire logic                recovery_enable_strap,
    input wire logic                two_cpus_installed,
    input wire frbw_pkg::frbw_err_t cpu_err,
    input wire logic                status_poll,
    input wire logic                alert_enable,
    // Outputs
    input wire logic                stop_flush,
    input wire logic                boot_recovery_reset_n,
    input wire logic                primary_bsp_inhibit,
    input wire logic                status_valid,
    input wire logic                alert
);
    logic [31:0] low_cnt;
    // Cycles of the current recovery pulse
    always_ff @(posedge core_clk)
        low_cnt <= (rst || boot_recovery_reset_n) ? 32'h0 : low_cnt + 32'h1;
    // ====================================
    // Properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_flush_pair: assert property (
        stop_flush != boot_recovery_reset_n) else $error("flush mismatch");
    chk_pulse_len: assert property ($rose(boot_recovery_reset_n)
        |-> low_cnt == RECOV_PULSE_CYCLES) else $error("pulse length");
    chk_inhibit_set: assert property ($rose(boot_recovery_reset_n)
        |-> primary_bsp_inhibit) else $error("inhibit not set");
    chk_inhibit_hold: assert property (primary_bsp_inhibit
        |=> primary_bsp_inhibit) else $error("inhibit dropped");
    chk_strap_gate: assert property ($fell(boot_recovery_reset_n)
        |-> recovery_enable_strap && two_cpus_installed)
        else $error("recovery not allowed");
    chk_halt_stops: assert property (!boot_timer_halt_n
        && !$past(boot_timer_halt_n) && !post_wdt_arm && boot_recovery_reset_n
        && !primary_bsp_inhibit |=> boot_recovery_reset_n)
        else $error("pulse after halt");
    chk_poll_answer: assert property (status_poll |=> status_valid)
        else $error("no status answer");
    chk_alert_rise: assert property (alert_enable
        && (cpu_err & ~$past(cpu_err)) != 4'h0 |=> alert)
        else $error("no alert");
    cov_failover: cover property ($fell(boot_recovery_reset_n));
    cov_alert: cover property (alert);
    cov_poll: cover property (status_valid);
endmodule // frbw_props

bind frbw_watchdog frbw_props #(
    .RECOV_PULSE_CYCLES(RECOV_PULSE_CYCLES)) u_props (.*);
`default_nettype wire

// ---- testbench/frbw_cpu_model.sv ----
// Model of the two processors and boot selection
`timescale 1ns/1ns
`default_nettype none
module frbw_cpu_model (
    // Clock, reset and scenario control
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic primary_ok,
    // Watchdog side
    input  wire logic boot_recovery_reset_n,
    input  wire logic primary_bsp_inhibit,
    output logic      boot_timer_halt_n
);
    int run_cnt = 0;
    // Cycles since the processors left reset
    always @(posedge core_clk)
        run_cnt <= (rst || !boot_recovery_reset_n) ? 0 : run_cnt + 1;
    // Healthy primary, or alternate once primary is barred, halts timer
    assign boot_timer_halt_n = !((primary_ok || primary_bsp_inhibit)
        && run_cnt >= 5);
endmodule // frbw_cpu_model
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench of the boot watchdog
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int BOOT = 20;
    localparam int POST = 30;
    localparam int PULSE = 10;
    logic core_clk, rst, arm, kick, strap, two, poll, aen, ok, halt_n;
    logic flush, rec_n, inh, valid, alert;
    frbw_pkg::frbw_err_t    err;
    frbw_pkg::frbw_status_t st;
    int n_mismatch = 0;
    int n_checks = 0;
    int n;
    frbw_watchdog #(.BOOT_TIMEOUT_CYCLES(BOOT), .POST_TIMEOUT_CYCLES(POST),
        .RECOV_PULSE_CYCLES(PULSE)) u_dut (.core_clk(core_clk), .rst(rst),
        .boot_timer_halt_n(halt_n), .post_wdt_arm(arm), .post_wdt_kick(kick),
        .recovery_enable_strap(strap), .two_cpus_installed(two),
        .cpu_err(err), .status_poll(poll), .alert_enable(aen),
        .stop_flush(flush), .boot_recovery_reset_n(rec_n),
        .primary_bsp_inhibit(inh), .status(st), .status_valid(valid),
        .alert(alert));
    frbw_cpu_model u_cpu (.core_clk(core_clk), .rst(rst), .primary_ok(ok),
        .boot_recovery_reset_n(rec_n), .primary_bsp_inhibit(inh),
        .boot_timer_halt_n(halt_n));
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    // ====================================
    // Shared tasks
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_rec(input logic lvl, output int cnt);
        for (cnt = 0; rec_n !== lvl; cnt++) begin
            cyc(1);
            if (cnt > 200) begin
                n_mismatch++;
                tally_and_finish();
            end
        end
    endtask
    task automatic start(input logic s, input logic t, input logic g);
        @(posedge core_clk);
        {rst, strap, two, ok, arm, kick, poll, aen, err} <= {1'h1, s, t, g, 8'h00};
        repeat (3) @(posedge core_clk);
        rst <= 1'h0;
        #1;
    endtask
    task automatic do_poll();
        @(posedge core_clk);
        poll <= 1'h1;
        @(posedge core_clk);
        poll <= 1'h0;
        #1;
        cmp(valid, 1);
    endtask
    // ====================================
    // Scenarios
    task automatic t_failover();
        start(1'h1, 1'h1, 1'h0);
        wait_rec(1'h0, n);
        cmp(n >= BOOT && n <= BOOT + 4, 1);
        cmp(flush, 1);
        wait_rec(1'h1, n);
        cmp(n, PULSE);
        cmp({flush, inh}, 2'h1);
        cyc(BOOT * 2);
        do_poll();
        cmp(st, {8'h00, frbw_pkg::ST_HALTED, 4'hB});
        $display("test failover done");
    endtask
    task automatic t_post();
        start(1'h1, 1'h1, 1'h1);
        cyc(BOOT * 2);
        cmp(rec_n, 1);
        @(posedge core_clk);
        arm <= 1'h1;
        cyc(POST - 5);
        @(posedge core_clk);
        kick <= 1'h1;
        @(posedge core_clk);
        kick <= 1'h0;
        wait_rec(1'h0, n);
        cmp(n >= POST - 3 && n <= POST + 3, 1);
        wait_rec(1'h1, n);
        cmp(n, PULSE);
        $display("test level two done");
    endtask
    task automatic t_straps();
        for (int i = 0; i < 3; i++) begin
            start(i[0], i[1], 1'h0);
            cyc(BOOT * 3);
            cmp(inh, 0);
            do_poll();
            cmp(st[3:0], {2'h2, i[0], i[1]});
        end
        $display("test straps done");
    endtask
    task automatic t_alert();
        start(1'h1, 1'h1, 1'h1);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            {aen, err} <= {1'h1, 4'h1 << i};
            cyc(1);
            cmp(alert, 1);
        end
        @(posedge core_clk);
        {aen, err} <= 5'h01;
        cyc(1);
        cmp(alert, 0);
        do_poll();
        cmp(st, {4'h1, 4'hF, frbw_pkg::ST_HALTED, 4'h3});
        do_poll();
        cmp(st.err_seen, 4'h1);
        $display("test alert done");
    endtask
    initial begin
        {rst, strap, two, ok, arm, kick, poll, aen, err} = 12'h800;
        t_failover();
        t_post();
        t_straps();
        t_alert();
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
